// ---- ssf_consts.svh ----
// Constants of the sensor sample FIFO: register offsets, fields, timing.
// Assumes inclusion by the package, the FIFO module, the host model and the testbench.
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH

`define SSF_ADDR_W          8
`define SSF_ADDR_COUNT_HIGH 8'h72
`define SSF_ADDR_COUNT_LOW  8'h73
`define SSF_ADDR_DATA_PORT  8'h74
`define SSF_RESET_BYTE      8'h00
`define SSF_CNT_W           13
`define SSF_CNT_HI_MSB      12
`define SSF_CNT_HI_LSB      8
`define SSF_CNT_LO_MSB      7
`define SSF_HI_RSVD_W       3
`define SSF_FIRST_REG       59
`define SSF_LAST_REG        96
`define SSF_FIRST_EXT_REG   73
`define SSF_NUM_BYTES       38
`define SSF_NUM_EXT         24
`define SSF_EN_TEMP         7
`define SSF_EN_GYRO_X       6
`define SSF_EN_GYRO_Y       5
`define SSF_EN_GYRO_Z       4
`define SSF_EN_ACCEL        3
`define SSF_ACCEL_LAST      64
`define SSF_TEMP_LAST       66
`define SSF_GYRO_X_LAST     68
`define SSF_GYRO_Y_LAST     70
`define SSF_SYS_CLK_HZ      40000000
`define SSF_INT_CLK_HZ      20000000
`define SSF_RESET_CYCLES    ((`SSF_SYS_CLK_HZ + `SSF_INT_CLK_HZ - 1) / `SSF_INT_CLK_HZ)

`endif

// ---- ssf_fifo.sv ----
// Sensor sample FIFO with count latch registers and a data port.
// Assumes register requests arrive on the system clock, one per cycle.
//
// Notes on behaviour
// - Fill count is 13 bits; high register holds bits 12..8, bits 7..5 read zero.
// - Reading the high count register latches the whole count into both registers.
// - One 8-bit data port: reads pop a byte, writes push a byte.
// - A sample tick outside a scan or FIFO reset appends enabled bytes of registers 59..96 in ascending order.
// - External bytes 73..96 join only when assigned to a slave whose group is on.
// - Each group is captured only while its enable flag is set; slave 3 separately.
// - Overflow sets the overflow flag automatically.
// - On overflow, mode 0 drops oldest bytes; mode 1 drops new data.
// - Reading an empty FIFO repeats the last popped byte and leaves the count.
// - FIFO reset bit clears the FIFO and clears itself after one 20 MHz cycle.
`timescale 1ns/1ps
`include "ssf_consts.svh"

module ssf_fifo #(
    parameter int DEPTH = 512
) (
    input  wire logic                        sys_clk_in,
    input  wire logic                        reset_n_in,
    input  wire ssf_pkg::ssf_reg_req_t       reg_req_in,
    input  wire logic                        sample_tick_in,
    input  wire logic [`SSF_NUM_BYTES*8-1:0] sensor_regs_in,
    input  wire logic [7:0]                  fifo_enable_in,
    input  wire logic                        slave3_fifo_en_in,
    input  wire logic [`SSF_NUM_EXT-1:0]     ext_assigned_in,
    input  wire logic [`SSF_NUM_EXT*2-1:0]   ext_slave_sel_in,
    input  wire logic                        stop_on_full_in,
    input  wire logic                        fifo_reset_req_in,
    input  wire logic                        overflow_clear_in,
    output logic [7:0]                       reg_rdata_out,
    output logic                             overflow_flag_out,
    output logic                             fifo_reset_bit_out
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [`SSF_CNT_W-1:0] DEPTH_CNT = `SSF_CNT_W'(DEPTH);
    localparam logic [1:0] RST_CYC = 2'(`SSF_RESET_CYCLES);
    localparam logic [5:0] LAST_IDX = 6'(`SSF_NUM_BYTES - 1);

    if (DEPTH < 2 || DEPTH > (1 << `SSF_CNT_W) - 1 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two between 2 and 4096");
    end

    // Reset release through two flops
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Per-byte capture enables
    logic [`SSF_NUM_BYTES-1:0] byte_en;
    logic [3:0]                slave_en;
    assign slave_en = {slave3_fifo_en_in, fifo_enable_in[2:0]};
    for (genvar i = 0; i < `SSF_NUM_BYTES; i++) begin : g_en
        localparam int REG = `SSF_FIRST_REG + i;
        if (REG >= `SSF_FIRST_EXT_REG) begin : g_ext
            localparam int K = REG - `SSF_FIRST_EXT_REG;
            assign byte_en[i] = ext_assigned_in[K] & slave_en[ext_slave_sel_in[2*K +: 2]];
        end else begin : g_core
            localparam int BIT = (REG <= `SSF_ACCEL_LAST)  ? `SSF_EN_ACCEL  :
                                 (REG <= `SSF_TEMP_LAST)   ? `SSF_EN_TEMP   :
                                 (REG <= `SSF_GYRO_X_LAST) ? `SSF_EN_GYRO_X :
                                 (REG <= `SSF_GYRO_Y_LAST) ? `SSF_EN_GYRO_Y : `SSF_EN_GYRO_Z;
            assign byte_en[i] = fifo_enable_in[BIT];
        end
    end

    logic [7:0]                   mem [DEPTH];
    logic [PW-1:0]                wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [`SSF_CNT_W-1:0]        count, next_count;
    logic [`SSF_CNT_W-1:0]        snap, next_snap;
    logic [7:0]                   last_pop, next_last_pop;
    logic [7:0]                   next_rdata;
    logic                         next_oflow;
    logic [1:0]                   rst_cnt, next_rst_cnt;
    logic                         next_rst_bit;
    ssf_pkg::ssf_scan_state_t     state, next_state;
    logic [5:0]                   idx, next_idx;
    logic [`SSF_NUM_BYTES*8-1:0]  cap_data, next_cap_data;
    logic [`SSF_NUM_BYTES-1:0]    cap_en, next_cap_en;
    logic                         push, pop, host_wr, mem_we;
    logic [7:0]                   push_byte;

    always_comb begin
        next_state    = state;
        next_idx      = idx;
        next_cap_data = cap_data;
        next_cap_en   = cap_en;
        next_wr_ptr   = wr_ptr;
        next_rd_ptr   = rd_ptr;
        next_count    = count;
        next_snap     = snap;
        next_last_pop = last_pop;
        next_rdata    = reg_rdata_out;
        next_oflow    = overflow_flag_out & ~overflow_clear_in;
        next_rst_cnt  = rst_cnt;
        next_rst_bit  = fifo_reset_bit_out;
        mem_we        = 1'b0;
        host_wr       = reg_req_in.wr && reg_req_in.addr == `SSF_ADDR_DATA_PORT;
        pop           = reg_req_in.rd && reg_req_in.addr == `SSF_ADDR_DATA_PORT
                        && count != '0;
        push          = host_wr;
        push_byte     = reg_req_in.wdata;
        // Capture walks one register per cycle; host writes stall it on enabled bytes
        case (state)
            ssf_pkg::SSF_IDLE: begin
                if (sample_tick_in && !fifo_reset_bit_out) begin
                    next_cap_data = sensor_regs_in;
                    next_cap_en   = byte_en;
                    next_idx      = '0;
                    next_state    = ssf_pkg::SSF_SCAN;
                end
            end
            ssf_pkg::SSF_SCAN: begin
                if (!(host_wr && cap_en[idx])) begin
                    if (cap_en[idx]) begin
                        push      = 1'b1;
                        push_byte = cap_data[8*idx +: 8];
                    end
                    next_idx = idx + 6'h01;
                    if (idx == LAST_IDX)
                        next_state = ssf_pkg::SSF_IDLE;
                end
            end
            default: next_state = ssf_pkg::SSF_IDLE;
        endcase
        if (reg_req_in.rd) begin
            case (reg_req_in.addr)
                `SSF_ADDR_COUNT_HIGH: begin
                    next_snap  = count;
                    next_rdata = {{`SSF_HI_RSVD_W{1'b0}},
                                  count[`SSF_CNT_HI_MSB:`SSF_CNT_HI_LSB]};
                end
                `SSF_ADDR_COUNT_LOW: next_rdata = snap[`SSF_CNT_LO_MSB:0];
                `SSF_ADDR_DATA_PORT: begin
                    next_rdata = pop ? mem[rd_ptr] : last_pop;
                    if (pop)
                        next_last_pop = mem[rd_ptr];
                end
                default: next_rdata = `SSF_RESET_BYTE;
            endcase
        end
        if (push) begin
            if (count == DEPTH_CNT && !pop) begin
                next_oflow = 1'b1;
                if (!stop_on_full_in) begin
                    mem_we      = 1'b1;
                    next_wr_ptr = wr_ptr + 1'b1;
                    next_rd_ptr = rd_ptr + 1'b1;
                end
            end else begin
                mem_we      = 1'b1;
                next_wr_ptr = wr_ptr + 1'b1;
                next_count  = count + `SSF_CNT_W'(1);
            end
        end
        if (pop) begin
            next_rd_ptr = rd_ptr + 1'b1;
            next_count  = (push && count != DEPTH_CNT) ? count : count - `SSF_CNT_W'(1);
            if (push && count == DEPTH_CNT)
                next_count = count;
        end
        if (fifo_reset_req_in)
            next_rst_bit = 1'b1;
        if (fifo_reset_bit_out) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count  = '0;
            mem_we      = 1'b0;
            next_state  = ssf_pkg::SSF_IDLE;
            next_rst_cnt = rst_cnt + 2'b01;
            if (rst_cnt + 2'b01 >= RST_CYC) begin
                next_rst_bit = fifo_reset_req_in;
                next_rst_cnt = '0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state              <= ssf_pkg::SSF_IDLE;
            idx                <= '0;
            cap_data           <= '0;
            cap_en             <= '0;
            wr_ptr             <= '0;
            rd_ptr             <= '0;
            count              <= '0;
            snap               <= '0;
            last_pop           <= `SSF_RESET_BYTE;
            reg_rdata_out      <= `SSF_RESET_BYTE;
            overflow_flag_out  <= 1'b0;
            rst_cnt            <= '0;
            fifo_reset_bit_out <= 1'b0;
        end else begin
            state              <= next_state;
            idx                <= next_idx;
            cap_data           <= next_cap_data;
            cap_en             <= next_cap_en;
            wr_ptr             <= next_wr_ptr;
            rd_ptr             <= next_rd_ptr;
            count              <= next_count;
            snap               <= next_snap;
            last_pop           <= next_last_pop;
            reg_rdata_out      <= next_rdata;
            overflow_flag_out  <= next_oflow;
            rst_cnt            <= next_rst_cnt;
            fifo_reset_bit_out <= next_rst_bit;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge sys_clk_in) begin
        if (mem_we)
            mem[wr_ptr] <= push_byte;
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n);

    logic rd_hi, rd_lo, rd_dp;
    assign rd_hi = reg_req_in.rd && reg_req_in.addr == `SSF_ADDR_COUNT_HIGH;
    assign rd_lo = reg_req_in.rd && reg_req_in.addr == `SSF_ADDR_COUNT_LOW;
    assign rd_dp = reg_req_in.rd && reg_req_in.addr == `SSF_ADDR_DATA_PORT;

    property p_hi_rsvd;
        rd_hi |=> reg_rdata_out[7:5] == 3'h0;
    endproperty
    a_hi_rsvd: assert property (p_hi_rsvd) else $error("high count reserved bits set");
    property p_snap;
        rd_hi ##1 !rd_hi ##1 rd_lo |=> reg_rdata_out == $past(count[7:0], 3);
    endproperty
    a_snap: assert property (p_snap) else $error("low count not from high-read snapshot");
    property p_empty_repeat;
        rd_dp && count == '0 && !push && !fifo_reset_bit_out |=>
            count == '0 && reg_rdata_out == $past(last_pop);
    endproperty
    a_empty_repeat: assert property (p_empty_repeat) else $error("empty read changed state");
    property p_pop_dec;
        pop && !push && !fifo_reset_bit_out |=> count == $past(count) - `SSF_CNT_W'(1);
    endproperty
    a_pop_dec: assert property (p_pop_dec) else $error("pop did not decrement count");
    property p_push_inc;
        push && !pop && count < DEPTH_CNT && !fifo_reset_bit_out |=>
            count == $past(count) + `SSF_CNT_W'(1);
    endproperty
    a_push_inc: assert property (p_push_inc) else $error("push did not increment count");
    property p_oflow;
        push && !pop && count == DEPTH_CNT && !fifo_reset_bit_out |=> overflow_flag_out;
    endproperty
    a_oflow: assert property (p_oflow) else $error("overflow flag not set");
    property p_keep_mode;
        push && !pop && count == DEPTH_CNT && stop_on_full_in && !fifo_reset_bit_out |=>
            wr_ptr == $past(wr_ptr) && rd_ptr == $past(rd_ptr);
    endproperty
    a_keep_mode: assert property (p_keep_mode) else $error("full FIFO accepted data");
    property p_reset_clear;
        $rose(fifo_reset_bit_out) |=> count == '0 ##[1:3] !fifo_reset_bit_out || fifo_reset_req_in;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("FIFO reset misbehaved");
    property p_scan_order;
        state == ssf_pkg::SSF_SCAN && !host_wr |=> idx == $past(idx) + 6'h01
            || state == ssf_pkg::SSF_IDLE;
    endproperty
    a_scan_order: assert property (p_scan_order) else $error("capture order broken");
    property p_gate;
        state == ssf_pkg::SSF_SCAN && !cap_en[idx] && !host_wr |-> !mem_we;
    endproperty
    a_gate: assert property (p_gate) else $error("disabled byte captured");

    c_overflow: cover property (push && count == DEPTH_CNT);
    c_empty_read: cover property (rd_dp && count == '0);
    c_scan_done: cover property (state == ssf_pkg::SSF_SCAN && idx == LAST_IDX);
    c_count_pair: cover property (rd_hi ##2 rd_lo);

endmodule : ssf_fifo

// ---- ssf_host_model.sv ----
// Host model: register reads and writes on the system clock.
// Assumes callers start each access just after a rising edge.
`timescale 1ns/1ps
`include "ssf_consts.svh"

module ssf_host_model (
    input  wire logic             sys_clk_in,
    input  wire logic [7:0]       reg_rdata_in,
    output ssf_pkg::ssf_reg_req_t reg_req_out
);
    initial reg_req_out = '0;

    // Request held over its taking edge, read data taken a cycle on
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                          input int gap, output logic [7:0] rdata);
        reg_req_out = '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
        @(posedge sys_clk_in);
        #1 reg_req_out = '0;
        @(posedge sys_clk_in);
        #1 rdata = reg_rdata_in;
        repeat (gap) begin
            @(posedge sys_clk_in);
            #1;
        end
    endtask : access

    task automatic read_count(output logic [15:0] cnt);
        access(1'b0, `SSF_ADDR_COUNT_HIGH, 8'h00, 0, cnt[15:8]);
        access(1'b0, `SSF_ADDR_COUNT_LOW, 8'h00, 0, cnt[7:0]);
    endtask : read_count

    task automatic pop(output logic [7:0] d);
        logic [15:0] cnt;
        read_count(cnt);
        d = 8'h00;
        if (cnt != 16'h0000)
            access(1'b0, `SSF_ADDR_DATA_PORT, 8'h00, 0, d);
    endtask : pop
endmodule : ssf_host_model

// ---- ssf_pkg.sv ----
// Types shared by the sensor sample FIFO.
// Assumes ssf_consts.svh is on the include path.
`include "ssf_consts.svh"

package ssf_pkg;

    typedef struct packed {
        logic                      rd;
        logic                      wr;
        logic [`SSF_ADDR_W-1:0]    addr;
        logic [7:0]                wdata;
    } ssf_reg_req_t;

    typedef enum logic [1:0] {
        SSF_IDLE = 2'b01,
        SSF_SCAN = 2'b10
    } ssf_scan_state_t;

endpackage : ssf_pkg

// ---- test_sensor_sample_fifo.sv ----
// Testbench of the sensor sample FIFO: host model, sensor stimulus, checks.
// Assumes a 40 MHz clock and the FIFO shrunk to eight bytes.
`timescale 1ns/1ps
`include "ssf_consts.svh"

module test_sensor_sample_fifo;
    ssf_pkg::ssf_reg_req_t       req;
    logic                        sys_clk_in;
    logic                        reset_n_in;
    logic                        tick;
    logic [`SSF_NUM_BYTES*8-1:0] sensor;
    logic [7:0]                  fifo_en;
    logic                        slave3_en;
    logic [`SSF_NUM_EXT-1:0]     ext_asg;
    logic [`SSF_NUM_EXT*2-1:0]   ext_sel;
    logic                        stop_full;
    logic                        rst_req;
    logic                        ovf_clr;
    logic [7:0]                  rdata;
    logic                        ovf;
    logic                        rst_bit;
    int                          fails;
    int                          checked;
    int                          cycles;

    ssf_fifo #(.DEPTH(8)) dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .reg_req_in(req), .sample_tick_in(tick), .sensor_regs_in(sensor),
        .fifo_enable_in(fifo_en), .slave3_fifo_en_in(slave3_en), .ext_assigned_in(ext_asg),
        .ext_slave_sel_in(ext_sel), .stop_on_full_in(stop_full), .fifo_reset_req_in(rst_req),
        .overflow_clear_in(ovf_clr), .reg_rdata_out(rdata), .overflow_flag_out(ovf),
        .fifo_reset_bit_out(rst_bit));
    ssf_host_model host (.sys_clk_in(sys_clk_in), .reg_rdata_in(rdata), .reg_req_out(req));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : cyc

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        host.access(1'b0, a, 8'h00, 0, d);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        logic [7:0] d;
        host.access(1'b1, a, w, 0, d);
    endtask : wr

    task automatic test_reset;
        logic [15:0] c;
        logic [7:0]  d;
        host.read_count(c);
        chk(c, 16'h0000);
        rd(`SSF_ADDR_DATA_PORT, d);
        chk(d, 8'h00);
        rd(8'h75, d);
        chk(d, 8'h00);
        wr(`SSF_ADDR_COUNT_HIGH, 8'hFF);
        host.read_count(c);
        chk(c, 16'h0000);
        chk(ovf, 1'b0);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_capture;
        logic [15:0] c;
        logic [7:0]  d;
        logic [7:0]  exp [8];
        exp = '{8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h49, 8'h4B};
        fifo_en = 8'h09;
        ext_asg = 24'h000007;
        ext_sel = 48'h000000000038;
        slave3_en = 1'b1;
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        cyc(42);
        host.read_count(c);
        chk(c, 16'h0008);
        for (int i = 0; i < 8; i++) begin
            host.pop(d);
            chk(d, exp[i]);
        end
        rd(`SSF_ADDR_DATA_PORT, d);
        chk(d, 8'h4B);
        host.read_count(c);
        chk(c, 16'h0000);
        fifo_en = 8'h00;
        $display("test_capture done");
    endtask : test_capture

    task automatic test_snapshot;
        logic [15:0] c;
        logic [7:0]  d;
        for (int i = 0; i < 3; i++)
            host.access(1'b1, `SSF_ADDR_DATA_PORT, 8'h20, 2, d);
        rd(`SSF_ADDR_COUNT_LOW, d);
        chk(d, 8'h00);
        host.read_count(c);
        chk(c, 16'h0003);
        $display("test_snapshot done");
    endtask : test_snapshot

    task automatic test_overflow(input logic mode);
        logic [15:0] c;
        logic [7:0]  d;
        rst_req = 1'b1;
        cyc(1);
        rst_req = 1'b0;
        cyc(4);
        stop_full = mode;
        for (int i = 0; i < 8; i++)
            wr(`SSF_ADDR_DATA_PORT, 8'(8'h10 + i));
        chk(ovf, 1'b0);
        wr(`SSF_ADDR_DATA_PORT, 8'h18);
        chk(ovf, 1'b1);
        host.read_count(c);
        chk(c, 16'h0008);
        rd(`SSF_ADDR_DATA_PORT, d);
        chk(d, mode ? 8'h10 : 8'h11);
        ovf_clr = 1'b1;
        cyc(1);
        ovf_clr = 1'b0;
        cyc(1);
        chk(ovf, 1'b0);
        $display("test_overflow done");
    endtask : test_overflow

    task automatic test_reset_bit;
        logic [15:0] c;
        int          n;
        wr(`SSF_ADDR_DATA_PORT, 8'h55);
        n = 0;
        rst_req = 1'b1;
        cyc(1);
        rst_req = 1'b0;
        repeat (6) begin
            if (rst_bit === 1'b1)
                n++;
            cyc(1);
        end
        chk(16'(n), 16'h0002);
        host.read_count(c);
        chk(c, 16'h0000);
        $display("test_reset_bit done");
    endtask : test_reset_bit

    // Temp, gyro Y and gyro Z groups, slave 3 gated off, host write stalls the scan
    task automatic test_groups;
        logic [15:0] c;
        logic [7:0]  d;
        logic [7:0]  exp [7];
        exp = '{8'h41, 8'h42, 8'h77, 8'h45, 8'h46, 8'h47, 8'h48};
        fifo_en = 8'hB0;
        slave3_en = 1'b0;
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        cyc(10);
        wr(`SSF_ADDR_DATA_PORT, 8'h77);
        cyc(40);
        host.read_count(c);
        chk(c, 16'h0007);
        for (int i = 0; i < 7; i++) begin
            host.pop(d);
            chk(d, exp[i]);
        end
        fifo_en = 8'h00;
        $display("test_groups done");
    endtask : test_groups

    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        {fails, checked, cycles} = '0;
        {reset_n_in, tick, fifo_en, slave3_en, ext_asg, ext_sel} = '0;
        {stop_full, rst_req, ovf_clr} = '0;
        for (int i = 0; i < `SSF_NUM_BYTES; i++)
            sensor[i*8 +: 8] = 8'(`SSF_FIRST_REG + i);
        cyc(16);
        reset_n_in = 1'b1;
        cyc(3);
        test_reset();
        test_capture();
        test_snapshot();
        test_overflow(1'b0);
        test_overflow(1'b1);
        test_reset_bit();
        test_groups();
        complete_run();
    end
endmodule : test_sensor_sample_fifo
